// *** rtl/pdcrr_defs.svh ***
// Constants for the PD class request responder: register offsets,
// field positions, reset values, request and selector codes.
// Assumes inclusion by bare name from the design file and the bench.
`ifndef PDCRR_DEFS_SVH
`define PDCRR_DEFS_SVH

// Register byte offsets
`define PDCRR_REG_CTRL      8'h00
`define PDCRR_REG_PORTS     8'h04
`define PDCRR_REG_CAPS      8'h08
`define PDCRR_REG_PDOCNT    8'h0C
`define PDCRR_REG_STATUS    8'h10
`define PDCRR_REG_MASK      8'h14
`define PDCRR_REG_PENDING   8'h18
`define PDCRR_REG_PDO_BASE  8'h20

// Control fields and reset values
`define PDCRR_CTRL_SPM      0
`define PDCRR_CTRL_HUB      1
`define PDCRR_CTRL_RST      2'h2
`define PDCRR_PORTS_RST     16'h0001
`define PDCRR_CAPS_RST      3'h2
`define PDCRR_PDOCNT_RST    3'h1

// Status and mask bits
`define PDCRR_ST_ACK        0
`define PDCRR_ST_STALL      1
`define PDCRR_ST_NOTIFY     2

// Request types
`define PDCRR_RT_PORT_OUT   8'h23
`define PDCRR_RT_PORT_IN    8'hA3
`define PDCRR_RT_DEV_IN     8'h80
`define PDCRR_RT_DEV_OUT    8'h00

// Request codes
`define PDCRR_RQ_GET_STATUS 8'h00
`define PDCRR_RQ_CLR_FEAT   8'h01
`define PDCRR_RQ_SET_FEAT   8'h03
`define PDCRR_RQ_GET_PDO    8'h14
`define PDCRR_RQ_GET_BATT   8'h15
`define PDCRR_RQ_SET_PDO    8'h16
`define PDCRR_RQ_GET_VDM    8'h17
`define PDCRR_RQ_SEND_VDM   8'h18

// Feature selectors
`define PDCRR_FS_BATT_WAKE  16'h0028
`define PDCRR_FS_OS_AWARE   16'h0029
`define PDCRR_FS_POLICY     16'h002A
`define PDCRR_FS_PORT_FIRST 16'h002B
`define PDCRR_FS_PORT_LAST  16'h0032
`define PDCRR_FS_CHARGING   16'h0036

// Lengths and descriptor layout
`define PDCRR_LEN_STATUS    16'h0008
`define PDCRR_LEN_CLEAR     16'h0002
`define PDCRR_DESC_TYPE     8'h10
`define PDCRR_DESC_HDR      6'h08
`define PDCRR_OFF_RSVD_A    6'h03
`define PDCRR_OFF_CAPS      6'h04
`define PDCRR_OFF_CAPS_HI   6'h05
`define PDCRR_OFF_COUNT     6'h06
`define PDCRR_OFF_RSVD_B    6'h07

`endif

// *** rtl/pdcrr_pkg.sv ***
// Types shared by the PD class request responder.
// Assumes the constants header sits beside it.
package pdcrr_pkg;
  // Gray codes along idle, scan, send
  typedef enum logic [1:0] {
    PDCRR_D_IDLE = 2'b00,
    PDCRR_D_SCAN = 2'b01,
    PDCRR_D_SEND = 2'b11
  } pdcrr_dstate_t;

  typedef enum logic [3:0] {
    PDCRR_K_NONE     = 4'h0,
    PDCRR_K_CLR_PORT = 4'h1,
    PDCRR_K_SET_PORT = 4'h2,
    PDCRR_K_GET_STAT = 4'h3,
    PDCRR_K_GET_PDO  = 4'h4,
    PDCRR_K_SET_PDO  = 4'h5,
    PDCRR_K_GET_VDM  = 4'h6,
    PDCRR_K_SEND_VDM = 4'h7,
    PDCRR_K_GET_BATT = 4'h8,
    PDCRR_K_SET_DEV  = 4'h9
  } pdcrr_kind_t;
endpackage

// *** rtl/pdcrr_responder.sv ***
// PD class request decoder and provider port descriptor generator.
// Assumes a USB device core on the same clock hands over setup packets,
// drains descriptor bytes and carries notifications to the host.
// Summary of operation
// [R1] One provider descriptor per provider port, ascending port order.
// [R2] Peripheral exposes at most one provider port; hub up to sixteen.
// [R3] Descriptor bytes at offsets 3 and 7 are zero.
// [R4] Capability bitmap at offset 4: BC, PD, Type-C; higher bits zero.
// [R5] Byte at offset 6 gives the number of power data objects.
// [R6] Power data objects start at offset 8, four bytes each, packed.
// [R7] Hub handles all PD class requests and events in any power role.
// [R8] Battery status query is always supported.
// [R9] Notify only port changes not caused by host software.
// [R10] Until policy manager active, no notifications; only battery query and the OS aware set feature.
// [R11] Port requests use types 23h and A3h; status queries return 8.
// [R12] Port requests for hubs only; battery and device feature for all.
// [R13] Request codes 20 to 24 are recognised.
// [R14] Device selectors 40,41,42,54; port selectors 43 to 50.
// [R15] Bad selector, port or length on port clear feature stalls.
// [R16] Unrecognised class requests stall.
//
// Chosen here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`include "pdcrr_defs.svh"

module pdcrr_responder #(
  parameter int NPORTS  = 16,
  parameter int MAX_PDO = 7,
  parameter logic [7:0] CAP_TYPE = 8'h0A  // Arbitrary capability type code
) (
  // Clock and reset
  input  wire logic                 clock_in,
  input  wire logic                 sys_rst_in,
  // Register port
  input  wire logic [7:0]           reg_addr_in,
  input  wire logic [31:0]          reg_wdata_in,
  input  wire logic                 reg_wr_in,
  input  wire logic                 reg_rd_in,
  output logic [31:0]               reg_rdata_out,
  // Setup packet
  input  wire logic                 setup_valid_in,
  input  wire logic [7:0]           setup_type_in,
  input  wire logic [7:0]           setup_req_in,
  input  wire logic [15:0]          setup_value_in,
  input  wire logic [15:0]          setup_index_in,
  input  wire logic [15:0]          setup_length_in,
  // Request answer
  output logic                      req_ack_out,
  output logic                      req_stall_out,
  output pdcrr_pkg::pdcrr_kind_t    req_kind_out,
  output logic [15:0]               req_value_out,
  output logic [7:0]                req_port_out,
  output logic [15:0]               req_len_out,
  // Descriptor stream
  input  wire logic                 desc_start_in,
  input  wire logic                 desc_ready_in,
  output logic                      desc_valid_out,
  output logic [7:0]                desc_byte_out,
  output logic                      desc_end_out,
  output logic                      desc_done_out,
  // Port events and notification
  input  wire logic [NPORTS-1:0]    port_change_in,
  input  wire logic                 host_caused_in,
  input  wire logic                 notify_taken_in,
  output logic                      notify_valid_out,
  output logic [NPORTS-1:0]         notify_map_out,
  // Interrupt
  output logic                      irq_out
);
  import pdcrr_pkg::*;

  logic [1:0]         ctrl;
  logic [15:0]        ports;
  logic [2:0]         caps;
  logic [2:0]         pdo_cnt;
  logic [31:0]        pdo [MAX_PDO];
  logic [2:0]         status;
  logic [2:0]         mask;
  logic [NPORTS-1:0]  pending;
  logic               spm_active;
  logic               is_hub;
  logic [2:0]         next_set;
  logic               next_ack;
  logic               next_stall;
  pdcrr_kind_t        next_kind;
  logic [15:0]        next_len;
  logic               port_ok;
  logic               spm_request;
  logic [NPORTS-1:0]  eff_ports;
  pdcrr_dstate_t      dstate;
  logic [4:0]         scan_port;
  logic [5:0]         byte_idx;
  logic [5:0]         desc_len;
  logic [5:0]         out_idx;
  logic [4:0]         out_port;
  logic               load;

  assign spm_active = ctrl[`PDCRR_CTRL_SPM];
  assign is_hub     = ctrl[`PDCRR_CTRL_HUB];
  // [R12] hub only ports
  assign port_ok    = is_hub && setup_index_in[7:0] != 8'h00 &&
                      {8'h00, setup_index_in[7:0]} <= 16'(NPORTS) &&
                      setup_index_in[15:8] == 8'h00;
  assign spm_request = setup_type_in == `PDCRR_RT_DEV_OUT &&
                       setup_req_in == `PDCRR_RQ_SET_FEAT &&
                       setup_value_in == `PDCRR_FS_OS_AWARE;
  // [R2] peripheral limit
  assign eff_ports = is_hub ? ports[NPORTS-1:0] :
                     {{(NPORTS-1){1'b0}}, ports[0]};
  assign desc_len  = `PDCRR_DESC_HDR + {1'b0, pdo_cnt, 2'b00};
  assign load      = !desc_valid_out || desc_ready_in;

  // Request decode; port scoped kinds reach here only on a hub
  always_comb begin
    next_kind = PDCRR_K_NONE;
    next_len  = 16'h0000;
    unique case ({setup_type_in, setup_req_in})
      // [R15] clear feature checks
      {`PDCRR_RT_PORT_OUT, `PDCRR_RQ_CLR_FEAT}:
        if (port_ok && setup_length_in == `PDCRR_LEN_CLEAR &&
            setup_value_in >= `PDCRR_FS_PORT_FIRST &&
            setup_value_in <= `PDCRR_FS_PORT_LAST) begin
          next_kind = PDCRR_K_CLR_PORT;
          next_len  = `PDCRR_LEN_CLEAR;
        end
      // [R14] port selectors
      {`PDCRR_RT_PORT_OUT, `PDCRR_RQ_SET_FEAT}:
        if (port_ok && setup_value_in >= `PDCRR_FS_PORT_FIRST &&
            setup_value_in <= `PDCRR_FS_PORT_LAST) begin
          next_kind = PDCRR_K_SET_PORT;
        end
      // [R13] request codes
      {`PDCRR_RT_PORT_OUT, `PDCRR_RQ_SET_PDO}:
        if (port_ok) begin
          next_kind = PDCRR_K_SET_PDO;
          next_len  = setup_length_in;
        end
      {`PDCRR_RT_PORT_OUT, `PDCRR_RQ_SEND_VDM}:
        if (port_ok) begin
          next_kind = PDCRR_K_SEND_VDM;
          next_len  = setup_length_in;
        end
      // [R11] port status returns eight bytes
      {`PDCRR_RT_PORT_IN, `PDCRR_RQ_GET_STATUS}:
        if (port_ok && setup_value_in == 16'h0001) begin
          next_kind = PDCRR_K_GET_STAT;
          next_len  = `PDCRR_LEN_STATUS;
        end
      {`PDCRR_RT_PORT_IN, `PDCRR_RQ_GET_PDO}:
        if (port_ok && setup_value_in <= 16'h0001) begin
          next_kind = PDCRR_K_GET_PDO;
          next_len  = setup_length_in;
        end
      {`PDCRR_RT_PORT_IN, `PDCRR_RQ_GET_VDM}:
        if (port_ok) begin
          next_kind = PDCRR_K_GET_VDM;
          next_len  = setup_length_in;
        end
      // [R8] battery query for every device
      {`PDCRR_RT_DEV_IN, `PDCRR_RQ_GET_BATT}:
        if (setup_value_in == 16'h0000) begin
          next_kind = PDCRR_K_GET_BATT;
          next_len  = `PDCRR_LEN_STATUS;
        end
      // [R14] device selectors
      {`PDCRR_RT_DEV_OUT, `PDCRR_RQ_SET_FEAT}:
        if (setup_value_in == `PDCRR_FS_BATT_WAKE ||
            setup_value_in == `PDCRR_FS_OS_AWARE ||
            setup_value_in == `PDCRR_FS_POLICY ||
            setup_value_in == `PDCRR_FS_CHARGING) begin
          next_kind = PDCRR_K_SET_DEV;
        end
      // [R16] anything else stalls
      default: next_kind = PDCRR_K_NONE;
    endcase
    // [R10] gate before policy manager is active
    if (!spm_active && next_kind != PDCRR_K_GET_BATT && !spm_request) begin
      next_kind = PDCRR_K_NONE;
      next_len  = 16'h0000;
    end
  end

  assign next_ack   = setup_valid_in && next_kind != PDCRR_K_NONE;
  assign next_stall = setup_valid_in && next_kind == PDCRR_K_NONE;

  // [R7] answer every request in any power role
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      req_ack_out   <= 1'b0;
      req_stall_out <= 1'b0;
      req_kind_out  <= PDCRR_K_NONE;
      req_value_out <= 16'h0000;
      req_port_out  <= 8'h00;
      req_len_out   <= 16'h0000;
    end else begin
      req_ack_out   <= next_ack;
      req_stall_out <= next_stall;
      if (setup_valid_in) begin
        req_kind_out  <= next_kind;
        req_value_out <= setup_value_in;
        req_port_out  <= setup_index_in[7:0];
        req_len_out   <= next_len;
      end
    end
  end

  // Registers written by software; the aware feature also sets the flag
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      ctrl    <= `PDCRR_CTRL_RST;
      ports   <= `PDCRR_PORTS_RST;
      caps    <= `PDCRR_CAPS_RST;
      pdo_cnt <= `PDCRR_PDOCNT_RST;
      mask    <= 3'h0;
    end else begin
      if (reg_wr_in) begin
        unique case (reg_addr_in)
          `PDCRR_REG_CTRL:   ctrl    <= reg_wdata_in[1:0];
          `PDCRR_REG_PORTS:  ports   <= reg_wdata_in[15:0];
          `PDCRR_REG_CAPS:   caps    <= reg_wdata_in[2:0];
          `PDCRR_REG_PDOCNT: pdo_cnt <= reg_wdata_in[2:0];
          `PDCRR_REG_MASK:   mask    <= reg_wdata_in[2:0];
          default: ;
        endcase
      end
      // Set wins over a same cycle software clear
      if (setup_valid_in && spm_request) begin
        ctrl[`PDCRR_CTRL_SPM] <= 1'b1;
      end
    end
  end

  // Storage for power data objects, shared by all provider ports
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      for (int i = 0; i < MAX_PDO; i++) begin
        pdo[i] <= 32'h00000000;
      end
    end else if (reg_wr_in) begin
      for (int i = 0; i < MAX_PDO; i++) begin
        if (reg_addr_in == `PDCRR_REG_PDO_BASE + 8'(i * 4)) begin
          pdo[i] <= reg_wdata_in;
        end
      end
    end
  end

  // Sticky status, cleared by reading it; a new event wins
  assign next_set = {notify_valid_out && notify_taken_in,
                     next_stall, next_ack};
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      status <= 3'h0;
      irq_out <= 1'b0;
    end else begin
      if (reg_rd_in && reg_addr_in == `PDCRR_REG_STATUS) begin
        status <= next_set;
      end else begin
        status <= status | next_set;
      end
      irq_out <= |(status & mask);
    end
  end

  // Read data one cycle after the strobe
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      reg_rdata_out <= 32'h00000000;
    end else if (reg_rd_in) begin
      reg_rdata_out <= 32'h00000000;
      unique case (reg_addr_in)
        `PDCRR_REG_CTRL:    reg_rdata_out[1:0]  <= ctrl;
        `PDCRR_REG_PORTS:   reg_rdata_out[15:0] <= ports;
        `PDCRR_REG_CAPS:    reg_rdata_out[2:0]  <= caps;
        `PDCRR_REG_PDOCNT:  reg_rdata_out[2:0]  <= pdo_cnt;
        `PDCRR_REG_STATUS:  reg_rdata_out[2:0]  <= status;
        `PDCRR_REG_MASK:    reg_rdata_out[2:0]  <= mask;
        `PDCRR_REG_PENDING: reg_rdata_out[NPORTS-1:0] <= pending;
        default: begin
          for (int i = 0; i < MAX_PDO; i++) begin
            if (reg_addr_in == `PDCRR_REG_PDO_BASE + 8'(i * 4)) begin
              reg_rdata_out <= pdo[i];
            end
          end
        end
      endcase
    end
  end

  // [R9] host caused changes are not reported
  // [R10] notifications held until the policy manager is active
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      pending          <= '0;
      notify_valid_out <= 1'b0;
      notify_map_out   <= '0;
    end else begin
      if (!notify_valid_out && spm_active && pending != '0) begin
        notify_valid_out <= 1'b1;
        notify_map_out   <= pending;
        pending <= host_caused_in ? '0 : port_change_in;
      end else begin
        if (notify_valid_out && notify_taken_in) begin
          notify_valid_out <= 1'b0;
        end
        if (!host_caused_in) begin
          pending <= pending | port_change_in;
        end
      end
    end
  end

  // [R1] descriptors walk ports upward from the lowest
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      dstate    <= PDCRR_D_IDLE;
      scan_port <= 5'h00;
      byte_idx  <= 6'h00;
    end else begin
      unique case (dstate)
        PDCRR_D_IDLE:
          if (desc_start_in) begin
            dstate    <= PDCRR_D_SCAN;
            scan_port <= 5'h00;
          end
        PDCRR_D_SCAN:
          if ({27'h0, scan_port} >= NPORTS) begin
            dstate <= PDCRR_D_IDLE;
          end else if (eff_ports[scan_port[$clog2(NPORTS)-1:0]]) begin
            dstate   <= PDCRR_D_SEND;
            byte_idx <= 6'h00;
          end else begin
            scan_port <= scan_port + 5'h01;
          end
        PDCRR_D_SEND:
          if (load) begin
            if (byte_idx == desc_len - 6'h01) begin
              dstate    <= PDCRR_D_SCAN;
              scan_port <= scan_port + 5'h01;
            end
            byte_idx <= byte_idx + 6'h01;
          end
      endcase
    end
  end

  // Byte register holds until the core takes it
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      desc_valid_out <= 1'b0;
      desc_byte_out  <= 8'h00;
      desc_end_out   <= 1'b0;
      desc_done_out  <= 1'b0;
      out_idx        <= 6'h00;
      out_port       <= 5'h00;
    end else begin
      desc_done_out <= dstate == PDCRR_D_SCAN &&
                       {27'h0, scan_port} >= NPORTS;
      if (load) begin
        desc_valid_out <= dstate == PDCRR_D_SEND;
        desc_end_out   <= byte_idx == desc_len - 6'h01;
        out_idx        <= byte_idx;
        out_port       <= scan_port;
        if (byte_idx >= `PDCRR_DESC_HDR) begin
          // [R6] packed objects, low byte first
          desc_byte_out <= 8'(pdo[3'((byte_idx - `PDCRR_DESC_HDR) >> 2)]
                           >> {byte_idx[1:0], 3'b000});
        end else begin
          unique case (byte_idx)
            6'h00: desc_byte_out <= {2'b00, desc_len};
            6'h01: desc_byte_out <= `PDCRR_DESC_TYPE;
            6'h02: desc_byte_out <= CAP_TYPE;
            // [R4] only three capability bits
            `PDCRR_OFF_CAPS:  desc_byte_out <= {5'h00, caps};
            // [R5] object count
            `PDCRR_OFF_COUNT: desc_byte_out <= {5'h00, pdo_cnt};
            // [R3] reserved bytes and upper bitmap byte
            default: desc_byte_out <= 8'h00;
          endcase
        end
      end
    end
  end

  // Checks
  logic [4:0] prev_port;
  logic       seen;
  always_ff @(posedge clock_in) begin
    if (sys_rst_in || desc_start_in) begin
      prev_port <= 5'h00;
      seen      <= 1'b0;
    end else if (desc_valid_out && desc_ready_in && out_idx == 6'h00) begin
      prev_port <= out_port;
      seen      <= 1'b1;
    end
  end

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);

  a_port_order: assert property ( // [R1]
    desc_valid_out && out_idx == 6'h00 && seen |-> out_port > prev_port)
    else $error("descriptor ports out of order");
  a_periph_single: assert property ( // [R2]
    !is_hub && desc_valid_out |-> out_port == 5'h00)
    else $error("peripheral sent a second provider port");
  a_reserved_zero: assert property ( // [R3]
    desc_valid_out && (out_idx == `PDCRR_OFF_RSVD_A ||
    out_idx == `PDCRR_OFF_RSVD_B) |-> desc_byte_out == 8'h00)
    else $error("reserved descriptor byte not zero");
  a_caps_upper: assert property ( // [R4]
    desc_valid_out && out_idx == `PDCRR_OFF_CAPS_HI |-> desc_byte_out == 8'h00)
    else $error("capability upper byte not zero");
  a_count_field: assert property ( // [R5]
    desc_valid_out && out_idx == `PDCRR_OFF_COUNT
    |-> desc_byte_out == {5'h00, pdo_cnt})
    else $error("object count byte wrong");
  a_length_field: assert property ( // [R6]
    desc_valid_out && out_idx == 6'h00
    |-> desc_byte_out == 8'(8 + 4 * pdo_cnt))
    else $error("descriptor length wrong");
  a_spm_gate: assert property ( // [R10]
    setup_valid_in && !spm_active && !spm_request &&
    setup_req_in != `PDCRR_RQ_GET_BATT |=> req_stall_out)
    else $error("request answered before policy manager active");
  a_notify_gate: assert property ( // [R10]
    $rose(notify_valid_out) |-> $past(spm_active))
    else $error("notification before policy manager active");
  a_batt_len: assert property ( // [R11]
    setup_valid_in && setup_type_in == `PDCRR_RT_DEV_IN &&
    setup_req_in == `PDCRR_RQ_GET_BATT && setup_value_in == 16'h0000
    |=> req_ack_out && req_len_out == `PDCRR_LEN_STATUS)
    else $error("battery query not answered with eight bytes");
  a_hub_only: assert property ( // [R12]
    setup_valid_in && !is_hub && setup_type_in == `PDCRR_RT_PORT_OUT
    |=> req_stall_out && !req_ack_out)
    else $error("port request accepted on peripheral");
  a_clear_len: assert property ( // [R15]
    setup_valid_in && setup_type_in == `PDCRR_RT_PORT_OUT &&
    setup_req_in == `PDCRR_RQ_CLR_FEAT && setup_length_in != `PDCRR_LEN_CLEAR
    |=> req_stall_out)
    else $error("clear feature with wrong length accepted");
  a_stall_unknown: assert property ( // [R16]
    setup_valid_in && setup_req_in > `PDCRR_RQ_SEND_VDM |=> req_stall_out)
    else $error("unknown request not stalled");
  a_host_quiet: assert property ( // [R9]
    host_caused_in && pending == '0 |=> pending == '0)
    else $error("host caused change was recorded");

  c_desc_done: cover property (desc_done_out && seen);
  c_notify:    cover property (notify_valid_out && notify_taken_in);
  c_clear_ok:  cover property (req_ack_out && req_kind_out == PDCRR_K_CLR_PORT);
  c_stall_pdo: cover property (desc_valid_out && !desc_ready_in ##1
                               desc_valid_out);
endmodule

// *** test/pd_class_request_responder_bench.sv ***
// Bench for the PD class request responder with a host side model.
// Assumes one clock; every scenario task checks its own results.
`timescale 1ns/1ps
`include "pdcrr_defs.svh"
module pd_class_request_responder_bench;
  import pdcrr_pkg::*;
  localparam logic [7:0] CT = 8'h5C;  // Arbitrary capability type
  logic        clock_in = '0, sys_rst_in = '1, reg_wr_in = '0;
  logic        reg_rd_in = '0, setup_valid_in = '0, desc_start_in = '0;
  logic        host_caused_in = '0, slow = '0, req_ack_out, req_stall_out;
  logic        desc_valid_out, desc_end_out, desc_done_out, irq_out;
  logic        notify_valid_out, desc_ready_in, notify_taken_in;
  logic [7:0]  reg_addr_in = '0, setup_type_in = '0, setup_req_in = '0;
  logic [7:0]  req_port_out, desc_byte_out;
  logic [15:0] setup_value_in = '0, setup_index_in = '0;
  logic [15:0] setup_length_in = '0, port_change_in = '0;
  logic [15:0] req_value_out, req_len_out, notify_map_out;
  logic [31:0] reg_wdata_in = '0, reg_rdata_out, rd_val;
  logic [15:0] rq[4] = '{16'hA314, 16'h2316, 16'hA317, 16'h2318};
  logic [15:0] ds[4] = '{16'h0028, 16'h0029, 16'h002A, 16'h0036};
  pdcrr_kind_t req_kind_out;
  int          fail_count = 0, samples_checked = 0, cycles = 0;

  pdcrr_responder #(.CAP_TYPE(CT)) i_dut (
    .clock_in, .sys_rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
    .reg_rd_in, .reg_rdata_out, .setup_valid_in, .setup_type_in,
    .setup_req_in, .setup_value_in, .setup_index_in, .setup_length_in,
    .req_ack_out, .req_stall_out, .req_kind_out, .req_value_out,
    .req_port_out, .req_len_out, .desc_start_in, .desc_ready_in,
    .desc_valid_out, .desc_byte_out, .desc_end_out, .desc_done_out,
    .port_change_in, .host_caused_in, .notify_taken_in,
    .notify_valid_out, .notify_map_out, .irq_out);
  pdcrr_host_model i_host (
    .clock_in, .sys_rst_in, .slow_in(slow), .desc_valid_in(desc_valid_out),
    .desc_byte_in(desc_byte_out), .desc_end_in(desc_end_out),
    .desc_ready_out(desc_ready_in), .notify_valid_in(notify_valid_out),
    .notify_map_in(notify_map_out), .notify_taken_out(notify_taken_in));

  always #12.5 clock_in = ~clock_in;
  // Run needs a few hundred cycles; a hang stops at the 20000 cycle cap
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      end_of_test();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t: saw %h, expected %h", $time, got, exp);
    end
  endtask
  task end_of_test;
    $display("checks %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clock_in);
    reg_wr_in <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge clock_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clock_in);
    reg_rd_in <= 1'b0;
    #1 rd_val = reg_rdata_out;
  endtask
  task su(input logic [7:0] t, r, input logic [15:0] v, ix, ln,
          input logic a);
    @(posedge clock_in);
    {setup_type_in, setup_req_in, setup_value_in, setup_index_in,
     setup_length_in} <= {t, r, v, ix, ln};
    setup_valid_in <= 1'b1;
    @(posedge clock_in);
    setup_valid_in <= 1'b0;
    #1 chk(req_ack_out, a);
    chk(req_stall_out, !a);
  endtask
  task pulse(input logic [15:0] m, input logic h);
    @(posedge clock_in);
    port_change_in <= m;
    host_caused_in <= h;
    @(posedge clock_in);
    port_change_in <= 16'h0000;
    host_caused_in <= 1'b0;
  endtask

  task t_regs;
    rd(`PDCRR_REG_CTRL);
    chk(rd_val, 32'h2);
    rd(`PDCRR_REG_PORTS);
    chk(rd_val, 32'h1);
    rd(`PDCRR_REG_CAPS);
    chk(rd_val, 32'h2);
    rd(`PDCRR_REG_PDOCNT);
    chk(rd_val, 32'h1);
    rd(8'hFC);
    chk(rd_val, 32'h0);
  endtask
  task t_decode;
    su(8'hA3, 8'h00, 16'h1, 16'h1, 16'h8, 0);
    su(8'h80, 8'h15, 16'h0, 16'h1, 16'h8, 1);
    chk(req_kind_out, PDCRR_K_GET_BATT);
    su(8'h00, 8'h03, 16'h29, 16'h0, 16'h0, 1);
    su(8'hA3, 8'h00, 16'h1, 16'h1, 16'h8, 1);
    chk(req_len_out, 16'h8);
    foreach (rq[i]) begin
      su(rq[i][15:8], rq[i][7:0], 16'h0, 16'h2, 16'h8, 1);
      chk(req_len_out, 16'h8);
    end
    su(8'hA3, 8'h19, 16'h0, 16'h2, 16'h8, 0);
    su(8'h23, 8'h15, 16'h0, 16'h2, 16'h8, 0);
  endtask
  task t_feat;
    foreach (ds[i]) su(8'h00, 8'h03, ds[i], 16'h0, 16'h0, 1);
    su(8'h00, 8'h03, 16'h2B, 16'h0, 16'h0, 0);
    for (int s = 16'h2B; s <= 16'h32; s++)
      su(8'h23, 8'h03, 16'(s), 16'h3, 16'h0, 1);
    su(8'h23, 8'h03, 16'h33, 16'h3, 16'h0, 0);
    su(8'h23, 8'h01, 16'h31, 16'h10, 16'h2, 1);
    chk(req_port_out, 8'h10);
    chk(req_len_out, 16'h2);
    chk(req_value_out, 16'h31);
    su(8'h23, 8'h01, 16'h33, 16'h3, 16'h2, 0);
    su(8'h23, 8'h01, 16'h31, 16'h0, 16'h2, 0);
    su(8'h23, 8'h01, 16'h31, 16'h11, 16'h2, 0);
    su(8'h23, 8'h01, 16'h31, 16'h3, 16'h3, 0);
  endtask
  task t_desc;
    logic [7:0] e[16];
    e = '{8'h10, `PDCRR_DESC_TYPE, CT, 8'h0, 8'h7, 8'h0, 8'h2, 8'h0,
          8'h44, 8'h33, 8'h22, 8'h11, 8'h88, 8'h77, 8'h66, 8'h55};
    wr(`PDCRR_REG_PORTS, 32'h5);
    wr(`PDCRR_REG_CAPS, 32'hFFFF);
    wr(`PDCRR_REG_PDOCNT, 32'h2);
    wr(`PDCRR_REG_PDO_BASE, 32'h11223344);
    wr(`PDCRR_REG_PDO_BASE + 8'h4, 32'h55667788);
    for (int k = 0; k < 2; k++) begin
      slow <= (k == 0);
      i_host.got.delete();
      i_host.ends = 0;
      @(posedge clock_in);
      desc_start_in <= 1'b1;
      @(posedge clock_in);
      desc_start_in <= 1'b0;
      for (int n = 0; n < 400 && desc_done_out !== 1'b1; n++)
        @(posedge clock_in) #1;
      chk(desc_done_out, 1);
      chk(i_host.got.size(), 32 - 16 * k);
      chk(i_host.ends, 2 - k);
      chk(i_host.got[3] | i_host.got[7], 0);
      chk({i_host.got[5], i_host.got[4]}, 7);
      chk(i_host.got[6], 2);
      foreach (i_host.got[i]) chk(i_host.got[i], e[i % 16]);
      wr(`PDCRR_REG_CTRL, 32'h1);
      su(8'h23, 8'h01, 16'h31, 16'h1, 16'h2, 0);
      su(8'h80, 8'h15, 16'h0, 16'h1, 16'h8, 1);
    end
  endtask
  task t_notify;
    int n0;
    wr(`PDCRR_REG_CTRL, 32'h3);
    wr(`PDCRR_REG_MASK, 32'h4);
    rd(`PDCRR_REG_STATUS);
    n0 = i_host.notes;
    pulse(16'h0004, 1);
    repeat (6) @(posedge clock_in);
    chk(i_host.notes, n0);
    wr(`PDCRR_REG_CTRL, 32'h2);
    pulse(16'h8001, 0);
    repeat (6) @(posedge clock_in);
    chk(i_host.notes, n0);
    wr(`PDCRR_REG_CTRL, 32'h3);
    repeat (6) @(posedge clock_in);
    #1 chk(i_host.notes, n0 + 1);
    chk(i_host.last_map, 16'h8001);
    chk(irq_out, 1);
    wr(`PDCRR_REG_MASK, 32'h0);
    repeat (2) @(posedge clock_in);
    #1 chk(irq_out, 0);
    rd(`PDCRR_REG_STATUS);
    chk(rd_val[2], 1);
    wr(`PDCRR_REG_MASK, 32'h4);
    repeat (2) @(posedge clock_in);
    #1 chk(irq_out, 0);
  endtask

  initial begin
    repeat (12) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    t_regs();
    t_decode();
    t_feat();
    t_desc();
    t_notify();
    end_of_test();
  end
endmodule

// *** test/pdcrr_host_model.sv ***
// Host side model: drains provider descriptor bytes, takes notifications.
// Assumes the responder on the same clock; slow_in stalls the drain.
`timescale 1ns/1ps
module pdcrr_host_model (
  // Clock and reset
  input  wire logic        clock_in,
  input  wire logic        sys_rst_in,
  // Bench control
  input  wire logic        slow_in,
  // Descriptor stream
  input  wire logic        desc_valid_in,
  input  wire logic [7:0]  desc_byte_in,
  input  wire logic        desc_end_in,
  output logic             desc_ready_out = 1'b0,
  // Notification
  input  wire logic        notify_valid_in,
  input  wire logic [15:0] notify_map_in,
  output logic             notify_taken_out = 1'b0
);
  logic [7:0]  got[$];
  logic [15:0] last_map;
  int          ends;
  int          notes;
  always @(posedge clock_in) begin
    if (sys_rst_in) begin
      desc_ready_out <= 1'b0;
      notify_taken_out <= 1'b0;
    end else begin
      // Stalling every other cycle shows that a byte holds until taken
      desc_ready_out <= slow_in ? ~desc_ready_out : 1'b1;
      if (desc_valid_in && desc_ready_out) begin
        got.push_back(desc_byte_in);
        if (desc_end_in) ends++;
      end
      notify_taken_out <= notify_valid_in && !notify_taken_out;
      if (notify_valid_in && notify_taken_out) begin
        last_map <= notify_map_in;
        notes++;
      end
    end
  end
endmodule
